// ---- single_wire_cfg.svh ----
`ifndef SINGLE_WIRE_CFG_SVH
`define SINGLE_WIRE_CFG_SVH

`define SW_CLK_MHZ         40
`define SW_CYC_UP(ns)      ((((ns) * `SW_CLK_MHZ) + 999) / 1000)

`define SW_PWRP_NS         1200000
`define SW_RSTL_STD_NS     480000
`define SW_RSTL_FAST_NS    70000
`define SW_RSTH_STD_NS     480000
`define SW_RSTH_FAST_NS    48000
`define SW_MSP_STD_NS      70000
`define SW_MSP_FAST_NS     9000
`define SW_W0L_STD_NS      60000
`define SW_W0L_FAST_NS     8000
`define SW_W1L_STD_NS      6000
`define SW_W1L_FAST_NS     1000
`define SW_MSR_STD_NS      13000
`define SW_MSR_FAST_NS     1750
`define SW_SLOT_STD_NS     70000
`define SW_SLOT_FAST_NS    12000
`define SW_REC_RST_NS      5000

`define SW_FAST_CMD        8'h3C
`define SW_FIFO_DEPTH      4

`endif

// ---- single_wire_master.sv ----
// Summary of operation
// RQ1: bytes go out and come in least significant bit first.
// RQ2: after reset release wait the power-up delay before any bus activity.
// RQ3: line lows during the power-up wait are ignored.
// RQ4: line idles high; this block is the sole master.
// RQ5: between transactions the line is left released high.
// RQ6: the slave sorts lows by length into slots or resets.
// RQ7: every slot starts with a falling edge that this block drives.
// RQ8: standard zero bit holds the line low 60 to 120 us.
// RQ9: fast zero bit holds the line low 8 to 16 us.
// RQ10: standard one bit is low at least 5 us, released before 15 us.
// RQ11: fast one bit is low at least 1 us, released before 2 us.
// RQ12: standard read slot opens with a low of 5 to under 15 us.
// RQ13: fast read slot opens with a low of 1 to under 2 us.
// RQ14: standard read sampled after release, before 15 us from slot start.
// RQ15: fast read sampled before 2 us from slot start.
// RQ16: standard presence sampled 60 to 75 us after reset release.
// RQ17: fast presence sampled 8.5 to 10 us after reset release.
// RQ18: low times run from the driven fall to the release.
// RQ19: slave needs a holdoff after each rise before the next fall.
// RQ20: slot lengths keep bit rates under 15.4 and 125 kbps.
// RQ21: the slave returns its 64-bit number as eight read bytes.
// RQ22: a 480 us reset returns to standard speed; short fast reset keeps fast.
// RQ23: slave answers reset after a delay with a presence low.
// RQ24: byte 3Ch sent first after reset switches to fast timing.
// RQ25: slave answers one by not pulling, zero by holding low.
// RQ26: slave starts at standard speed and waits for a reset.
`include "single_wire_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module single_wire_master
    import single_wire_pkg::*;
#(
    parameter int POWERUP_CYC  = `SW_CYC_UP(`SW_PWRP_NS),
    parameter int RSTL_STD_CYC = `SW_CYC_UP(`SW_RSTL_STD_NS),
    parameter int RSTH_STD_CYC = `SW_CYC_UP(`SW_RSTH_STD_NS),
    parameter int FIFO_DEPTH   = `SW_FIFO_DEPTH
)
(
    input  wire logic    ref_clk,   // 40 MHz clock
    input  wire logic    arst_n,    // async reset, active low
    input  wire logic    clkEn,     // freezes all state while low
    input  wire logic    cmdValid,  // command offered
    output logic         cmdReady,  // command taken when both high
    input  wire cmd_t    cmdIn,     // command word
    output logic         resValid,  // result available
    input  wire logic    resReady,  // result consumed
    output result_t      resOut,    // presence or read byte
    input  wire logic    lineIn,    // bus level from pin
    output logic         lineOut,   // value driven, always low
    output logic         lineOe_n,  // low while pulling the bus
    output logic         fastSpeed, // fast timing in use
    output logic         busy       // transaction in progress
);
    localparam logic [15:0] RSTL_FAST = 16'(`SW_CYC_UP(`SW_RSTL_FAST_NS));
    localparam logic [15:0] RSTH_FAST = 16'(`SW_CYC_UP(`SW_RSTH_FAST_NS));
    localparam logic [15:0] MSP_STD   = 16'(`SW_CYC_UP(`SW_MSP_STD_NS));
    localparam logic [15:0] MSP_FAST  = 16'(`SW_CYC_UP(`SW_MSP_FAST_NS));
    localparam logic [15:0] W0L_STD   = 16'(`SW_CYC_UP(`SW_W0L_STD_NS));
    localparam logic [15:0] W0L_FAST  = 16'(`SW_CYC_UP(`SW_W0L_FAST_NS));
    localparam logic [15:0] W1L_STD   = 16'(`SW_CYC_UP(`SW_W1L_STD_NS));
    localparam logic [15:0] W1L_FAST  = 16'(`SW_CYC_UP(`SW_W1L_FAST_NS));
    localparam logic [15:0] MSR_STD   = 16'(`SW_CYC_UP(`SW_MSR_STD_NS));
    localparam logic [15:0] MSR_FAST  = 16'(`SW_CYC_UP(`SW_MSR_FAST_NS));
    localparam logic [15:0] SLOT_STD  = 16'(`SW_CYC_UP(`SW_SLOT_STD_NS));
    localparam logic [15:0] SLOT_FAST = 16'(`SW_CYC_UP(`SW_SLOT_FAST_NS));
    localparam logic [15:0] REC_RST   = 16'(`SW_CYC_UP(`SW_REC_RST_NS));
    localparam logic [15:0] PWR_LEN   = 16'(POWERUP_CYC);
    localparam logic [15:0] RSTL_STD  = 16'(RSTL_STD_CYC);
    localparam logic [15:0] RSTH_STD  = 16'(RSTH_STD_CYC);

    if (POWERUP_CYC < 1 || POWERUP_CYC > 65535 || RSTL_STD_CYC < 1
        || RSTL_STD_CYC > 65535 || RSTH_STD_CYC <= `SW_CYC_UP(`SW_MSP_STD_NS)
        || RSTH_STD_CYC > 65535)
    begin : g_bad_counts
        $error("single_wire_master counts out of the 16-bit timer range");
    end

    state_t      state_ff;
    state_t      nxt_state;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    cmd_t        cmd_ff;
    cmd_t        nxt_cmd;
    logic [7:0]  shift_ff;
    logic [7:0]  nxt_shift;
    logic [2:0]  bitIdx_ff;
    logic [2:0]  nxt_bitIdx;
    logic        fast_ff;
    logic        nxt_fast;
    logic        firstByte_ff;
    logic        nxt_firstByte;
    logic        rstStd_ff;
    logic        nxt_rstStd;
    logic        pres_ff;
    logic        nxt_pres;
    result_t     res_ff;
    result_t     nxt_res;
    logic        drive_ff;
    logic        nxt_drive;
    logic        lineHigh;
    logic        fifoInValid;
    logic        fifoInReady;
    logic [15:0] rstLowLen;
    logic [15:0] rstHighLen;
    logic [15:0] mspPt;
    logic [15:0] msrPt;
    logic [15:0] slotLen;
    logic [15:0] lowLen;

    sw_sync2 u_sync
    (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .asyncIn (lineIn),
        .syncOut (lineHigh)
    );

    sw_fifo #(.WIDTH($bits(result_t)), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (res_ff),
        .outValid (resValid),
        .outReady (resReady),
        .outData  (resOut)
    );

    always_comb
    begin
        rstLowLen  = rstStd_ff ? RSTL_STD : RSTL_FAST;                   // [RQ22]
        rstHighLen = rstStd_ff ? RSTH_STD : RSTH_FAST;
        mspPt      = rstStd_ff ? MSP_STD : MSP_FAST;                     // [RQ16] [RQ17]
        msrPt      = fast_ff ? MSR_FAST : MSR_STD;                       // [RQ14] [RQ15]
        slotLen    = fast_ff ? SLOT_FAST : SLOT_STD;                     // [RQ20]
        cmdReady   = (state_ff == ST_IDLE);
        fifoInValid = (state_ff == ST_PUSH);
        busy       = (state_ff != ST_IDLE);
    end

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff + 16'h0001;
        nxt_cmd       = cmd_ff;
        nxt_shift     = shift_ff;
        nxt_bitIdx    = bitIdx_ff;
        nxt_fast      = fast_ff;
        nxt_firstByte = firstByte_ff;
        nxt_rstStd    = rstStd_ff;
        nxt_pres      = pres_ff;
        nxt_res       = res_ff;
        lowLen        = 16'h0000;
        case (state_ff)
            ST_POWERUP:
            begin
                // line is not looked at here: early presence lows are harmless
                if (cnt_ff == PWR_LEN - 16'h0001)                          // [RQ2] [RQ3]
                begin
                    nxt_state = ST_IDLE;
                    nxt_cnt   = 16'h0000;
                end
            end
            ST_IDLE:
            begin
                nxt_cnt = 16'h0000;
                if (cmdValid)
                begin
                    nxt_cmd    = cmdIn;
                    nxt_shift  = cmdIn.data;
                    nxt_bitIdx = 3'h0;
                    nxt_rstStd = cmdIn.longReset || !fast_ff;
                    nxt_state  = (cmdIn.op == CMD_RESET) ? ST_RECOVER : ST_WAIT_HIGH;
                end
            end
            ST_RECOVER:
            begin
                // released line must stay high a full recovery before the reset low
                if (!lineHigh)                                               // [RQ5] [RQ19]
                begin
                    nxt_cnt = 16'h0000;
                end
                else if (cnt_ff == REC_RST - 16'h0001)
                begin
                    nxt_state = ST_RST_LOW;
                    nxt_cnt   = 16'h0000;
                end
            end
            ST_RST_LOW:
            begin
                if (cnt_ff == rstLowLen - 16'h0001)                          // [RQ18]
                begin
                    nxt_state = ST_RST_HIGH;
                    nxt_cnt   = 16'h0000;
                    if (rstStd_ff)
                    begin
                        nxt_fast = 1'b0;                                     // [RQ22]
                    end
                end
            end
            ST_RST_HIGH:
            begin
                if (cnt_ff == mspPt)
                begin
                    nxt_pres = !lineHigh;                                    // [RQ23]
                end
                if (cnt_ff == rstHighLen - 16'h0001)
                begin
                    nxt_firstByte = 1'b1;                                    // [RQ26]
                    nxt_res       = '{isPresence: 1'b1, data: {7'h00, pres_ff}};
                    nxt_state     = ST_PUSH;
                end
            end
            ST_WAIT_HIGH:
            begin
                // a slave still holding low would swallow our falling edge
                nxt_cnt = 16'h0000;
                if (lineHigh)                                                // [RQ4] [RQ7]
                begin
                    nxt_state = ST_SLOT;
                end
            end
            ST_SLOT:
            begin
                if (cmd_ff.op == CMD_READ && cnt_ff == msrPt)
                begin
                    nxt_shift = {lineHigh, shift_ff[7:1]};                   // [RQ1] [RQ25]
                end
                if (cnt_ff == slotLen - 16'h0001)
                begin
                    nxt_bitIdx = bitIdx_ff + 3'h1;
                    nxt_cnt    = 16'h0000;
                    nxt_state  = ST_WAIT_HIGH;
                    if (cmd_ff.op == CMD_WRITE)
                    begin
                        nxt_shift = {1'b0, shift_ff[7:1]};                   // [RQ1]
                    end
                    if (bitIdx_ff == 3'h7)
                    begin
                        nxt_firstByte = 1'b0;
                        if (cmd_ff.op == CMD_WRITE)
                        begin
                            nxt_state = ST_IDLE;
                            if (firstByte_ff && cmd_ff.data == `SW_FAST_CMD)
                            begin
                                nxt_fast = 1'b1;                             // [RQ24]
                            end
                        end
                        else
                        begin
                            nxt_res   = '{isPresence: 1'b0, data: shift_ff}; // [RQ21]
                            nxt_state = ST_PUSH;
                        end
                    end
                end
            end
            ST_PUSH:
            begin
                // full result buffer stalls the bus between slots, never inside one
                nxt_cnt = 16'h0000;
                if (fifoInReady)
                begin
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_cnt   = 16'h0000;
            end
        endcase
        if (!clkEn)
        begin
            nxt_state     = state_ff;
            nxt_cnt       = cnt_ff;
            nxt_cmd       = cmd_ff;
            nxt_shift     = shift_ff;
            nxt_bitIdx    = bitIdx_ff;
            nxt_fast      = fast_ff;
            nxt_firstByte = firstByte_ff;
            nxt_rstStd    = rstStd_ff;
            nxt_pres      = pres_ff;
            nxt_res       = res_ff;
        end
        if (nxt_cmd.op == CMD_WRITE && !nxt_shift[0])
        begin
            lowLen = nxt_fast ? W0L_FAST : W0L_STD;                          // [RQ8] [RQ9]
        end
        else
        begin
            lowLen = nxt_fast ? W1L_FAST : W1L_STD;                          // [RQ10] [RQ11] [RQ12] [RQ13]
        end
        nxt_drive = (nxt_state == ST_RST_LOW)
                 || (nxt_state == ST_SLOT && nxt_cnt < lowLen);              // [RQ7] [RQ18]
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff     <= ST_POWERUP;
            cnt_ff       <= 16'h0000;
            cmd_ff       <= '{op: CMD_RESET, longReset: 1'b1, data: 8'h00};
            shift_ff     <= 8'h00;
            bitIdx_ff    <= 3'h0;
            fast_ff      <= 1'b0;
            firstByte_ff <= 1'b0;
            rstStd_ff    <= 1'b1;
            pres_ff      <= 1'b0;
            res_ff       <= '{isPresence: 1'b0, data: 8'h00};
            drive_ff     <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            cmd_ff       <= nxt_cmd;
            shift_ff     <= nxt_shift;
            bitIdx_ff    <= nxt_bitIdx;
            fast_ff      <= nxt_fast;
            firstByte_ff <= nxt_firstByte;
            rstStd_ff    <= nxt_rstStd;
            pres_ff      <= nxt_pres;
            res_ff       <= nxt_res;
            drive_ff     <= nxt_drive;
        end
    end

    assign lineOut   = 1'b0;
    assign lineOe_n  = !drive_ff;
    assign fastSpeed = fast_ff;

    a_quiet_powerup: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ2]
        state_ff == ST_POWERUP |-> lineOe_n && !cmdReady)
        else $error("bus touched during power-up wait");

    a_drive_states: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ7]
        !lineOe_n |-> (state_ff == ST_RST_LOW || state_ff == ST_SLOT))
        else $error("line pulled outside reset or slot");

    a_slot_low_len: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ8]
        state_ff == ST_SLOT && cmd_ff.op == CMD_WRITE && !shift_ff[0] && !fast_ff
        |-> (!lineOe_n == (cnt_ff < W0L_STD)))
        else $error("standard zero low length wrong");

    a_one_release: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ10]
        state_ff == ST_SLOT && !(cmd_ff.op == CMD_WRITE && !shift_ff[0])
        |-> (!lineOe_n == (cnt_ff < (fast_ff ? W1L_FAST : W1L_STD))))
        else $error("one or read low length wrong");

    a_sample_released: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ14]
        state_ff == ST_SLOT && cmd_ff.op == CMD_READ && cnt_ff == msrPt
        |-> lineOe_n && $past(lineOe_n, 2))
        else $error("read sampled while still driving");

    a_reset_length: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ22]
        $rose(lineOe_n) && $past(state_ff) == ST_RST_LOW
        |-> $past(cnt_ff) == rstLowLen - 16'h0001)
        else $error("reset low length wrong");

    a_fast_clear: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ22]
        $fell(fast_ff) |-> $past(state_ff) == ST_RST_LOW && rstStd_ff)
        else $error("fast speed left without long reset");

    a_fast_set: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ24]
        $rose(fast_ff) |-> $past(firstByte_ff) && $past(cmd_ff.data) == `SW_FAST_CMD)
        else $error("fast speed entered without the switch byte");

    a_start_high: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ4]
        $rose(state_ff == ST_SLOT) |-> $past(lineHigh) ##1 !lineOe_n[*1])
        else $error("slot started on a low line");

    a_push_stall: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ21]
        state_ff == ST_PUSH && !fifoInReady |=> state_ff == ST_PUSH && lineOe_n)
        else $error("result dropped under back-pressure");
endmodule : single_wire_master
`default_nettype wire

// ---- single_wire_master_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module single_wire_master_test;
    import single_wire_pkg::*;
    localparam logic [63:0] ROM_ID = 64'h5A3C_96E1_7B24_D810; // arbitrary value
    logic    ref_clk = 0, arst_n = 0, cmdValid = 0, resReady = 0, clkEn = 1;
    logic    cmdReady, resValid, lineOut, lineOe_n, fastSpeed, busy, pull_n, lineBus;
    cmd_t    cmdIn = '0;
    result_t resOut;
    int      mismatches = 0, checks_done = 0, lowRun = 0;
    int      lows[$];
    assign lineBus = (lineOe_n ? 1'b1 : lineOut) & pull_n;
    single_wire_master #(.POWERUP_CYC(50), .RSTL_STD_CYC(4000), .RSTH_STD_CYC(4000)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdIn(cmdIn), .resValid(resValid), .resReady(resReady),
        .resOut(resOut), .lineIn(lineBus), .lineOut(lineOut), .lineOe_n(lineOe_n),
        .fastSpeed(fastSpeed), .busy(busy));
    sw_slave_model #(.ROM_ID(ROM_ID)) model_u (.ref_clk(ref_clk), .bus(lineBus),
        .pull_n(pull_n));
    initial forever #12.5 ref_clk = ~ref_clk;
    // master low lengths, recorded at release
    always @(posedge ref_clk)
    begin
        if (!lineOe_n) lowRun++;
        else if (lowRun > 0)
        begin
            lows.push_back(lowRun);
            lowRun = 0;
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic tick();
        @(posedge ref_clk) #2;
    endtask : tick
    task automatic send(input cmd_op_t op, input logic lr, input logic [7:0] d);
        int n = 0;
        tick();
        cmdValid = 1;
        cmdIn = '{op, lr, d};
        while (cmdReady !== 1'b1 && n++ < 30000) tick();
        check("cmd accept", 1, n <= 30000);
        tick();
        cmdValid = 0;
    endtask : send
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n++ < 30000) tick();
        check("idle wait", 1, n <= 30000);
    endtask : wait_idle
    task automatic take(input logic [8:0] exp, input string name);
        int n = 0;
        // one edge with resReady low between two pops
        tick();
        while (resValid !== 1'b1 && n++ < 30000) tick();
        check("result wait", 1, n <= 30000);
        check(name, exp, resOut);
        resReady = 1;
        tick();
        resReady = 0;
    endtask : take
    task automatic check_lows(input logic [7:0] d, input int zl, input int ol);
        for (int i = 0; i < 8; i++) check("bit low", d[i] ? ol : zl, lows[i]);
    endtask : check_lows
    task automatic test_powerup();
        int n = 0;
        check("busy in wait", 1, busy);
        while (cmdReady !== 1'b1 && n++ < 200) tick();
        check("powerup wait", 1, n >= 48 && n <= 52);
        check("line quiet", 0, lows.size());
        check("line out", 0, lineOut);
    endtask : test_powerup
    task automatic test_reset(input logic lr, input int lowLen, input logic spd);
        lows.delete();
        send(CMD_RESET, lr, 8'h00);
        take(9'h101, "presence");
        check("reset low", lowLen, lows[0]);
        check("speed", spd, fastSpeed);
    endtask : test_reset
    task automatic test_write(input logic [7:0] d, input int zl, input int ol);
        lows.delete();
        send(CMD_WRITE, 0, d);
        wait_idle();
        check_lows(d, zl, ol);
    endtask : test_write
    task automatic test_fast_reads();
        lows.delete();
        for (int i = 0; i < 5; i++) send(CMD_READ, 0, 8'h00);
        repeat (4000) tick();
        // fifo full after four bytes, fifth waits in the block
        check("stall on full", 2'b10, {busy, cmdReady});
        // a pop offered while frozen must not take the head word
        clkEn = 0;
        resReady = 1;
        tick();
        resReady = 0;
        clkEn = 1;
        for (int i = 0; i < 5; i++) take({1'b0, ROM_ID[8*i+:8]}, "rom byte");
        wait_idle();
        check("read low", 40, lows[39]);
    endtask : test_fast_reads
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
    initial
    begin
        repeat (10) tick();
        arst_n = 1;
        test_powerup();
        test_reset(0, 4000, 0);
        test_write(8'h3C, 2400, 240);
        check("speed up", 1, fastSpeed);
        test_reset(0, 2800, 1);
        test_write(8'h33, 320, 40);
        test_fast_reads();
        test_reset(1, 4000, 0);
        stop_test();
    end
endmodule : single_wire_master_test
`default_nettype wire

// ---- single_wire_pkg.sv ----
`default_nettype none
package single_wire_pkg;

    typedef enum logic [1:0] {
        CMD_RESET,
        CMD_WRITE,
        CMD_READ
    } cmd_op_t;

    typedef struct packed {
        cmd_op_t    op;
        logic       longReset;
        logic [7:0] data;
    } cmd_t;

    typedef struct packed {
        logic       isPresence;
        logic [7:0] data;
    } result_t;

    typedef enum logic [3:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_RECOVER,
        ST_RST_LOW,
        ST_RST_HIGH,
        ST_WAIT_HIGH,
        ST_SLOT,
        ST_PUSH
    } state_t;

endpackage : single_wire_pkg
`default_nettype wire

// ---- sw_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sw_fifo
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
)
(
    input  wire logic             ref_clk,  // clock
    input  wire logic             arst_n,   // async reset
    input  wire logic             clkEn,    // clock enable
    input  wire logic             inValid,  // write request
    output logic                  inReady,  // not full
    input  wire logic [WIDTH-1:0] inData,   // write word
    output logic                  outValid, // not empty
    input  wire logic             outReady, // read accept
    output logic      [WIDTH-1:0] outData   // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("sw_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    logic [AW-1:0]    nxt_wrPtr;
    logic [AW-1:0]    nxt_rdPtr;
    logic [AW:0]      nxt_count;
    logic             doWr;
    logic             doRd;

    always_comb
    begin
        inReady   = (count_ff != (AW+1)'(DEPTH));
        outValid  = (count_ff != '0);
        doWr      = clkEn && inValid && inReady;
        doRd      = clkEn && outValid && outReady;
        nxt_wrPtr = doWr ? wrPtr_ff + 1'b1 : wrPtr_ff;
        nxt_rdPtr = doRd ? rdPtr_ff + 1'b1 : rdPtr_ff;
        nxt_count = count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
        end
    end

    // storage needs no reset; reads are gated by outValid
    always_ff @(posedge ref_clk)
    begin
        if (doWr)
        begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    assign outData = mem_ff[rdPtr_ff];
endmodule : sw_fifo
`default_nettype wire

// ---- sw_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sw_slave_model
#(
    parameter logic [63:0] ROM_ID  = 64'h5A3C_96E1_7B24_D810, // arbitrary value
    parameter int          STD_RST = 3200
)
(
    input  wire logic ref_clk, // sim clock
    input  wire logic bus,     // resolved line
    output logic      pull_n   // low while pulling
);
    int cyc = 0, lowLen = 0, pullCnt = 0, waitCnt = 0, rx = 0, bitIdx = 0, hiAge = 0;
    logic fast = 0, armed = 0, tx = 0, prevBus = 1;
    logic [7:0] sr = '0;
    logic pulling = 1'b0;
    assign pull_n = !pulling;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (waitCnt == 1) pullCnt = fast ? 320 : 2400;
        if (waitCnt > 0) waitCnt--;
        else if (pullCnt > 0) pullCnt--;
        // only the master's fall opens a slot
        // a fall too soon after the last rise is not seen as a slot
        if (!bus && prevBus && pullCnt == 0 && tx && hiAge >= (fast ? 20 : 50))
        begin
            if (!ROM_ID[bitIdx]) pullCnt = fast ? 80 : 600;
            bitIdx++;
        end
        if (!bus && pull_n) lowLen++;
        if (bus && !prevBus && lowLen > 0)
        begin
            if (lowLen >= STD_RST || (fast && lowLen >= 1000))
            begin
                if (lowLen >= STD_RST) fast = 0;
                waitCnt = fast ? 80 : 600;
                armed = 1;
                tx = 0;
                rx = 0;
                bitIdx = 0;
            end
            else if (armed && !tx)
            begin
                sr = {lowLen < (fast ? 160 : 1200), sr[7:1]};
                rx++;
                tx = (rx == 8);
                if (tx && sr == 8'h3C) fast = 1;
            end
            lowLen = 0;
        end
        prevBus = bus;
        hiAge = bus ? hiAge + 1 : 0;
        pulling <= (pullCnt > 0 || (cyc > 20 && cyc < 40));
    end
endmodule : sw_slave_model
`default_nettype wire

// ---- sw_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module sw_sync2
(
    input  wire logic ref_clk,  // clock
    input  wire logic arst_n,   // async reset
    input  wire logic clkEn,    // clock enable
    input  wire logic asyncIn,  // raw pin level
    output logic      syncOut   // synchronised level
);
    logic stage1_ff;
    logic stage2_ff;
    logic nxt_stage1;
    logic nxt_stage2;

    always_comb
    begin
        nxt_stage1 = clkEn ? asyncIn : stage1_ff;
        nxt_stage2 = clkEn ? stage1_ff : stage2_ff;
    end

    // idle bus is high, so reset to high
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_ff <= 1'b1;
            stage2_ff <= 1'b1;
        end
        else
        begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign syncOut = stage2_ff;
endmodule : sw_sync2
`default_nettype wire
